// [pkg/rfb_cfg.svh]
// constants for the register file and byte-order block
`ifndef RFB_CFG_SVH
`define RFB_CFG_SVH
`define RFB_NUM_DATA 8
`define RFB_NUM_ADDR 8
`define RFB_SP_IDX 3'h7
`define RFB_BYTE_MSB 7
`define RFB_WORD_MSB 15
`define RFB_LONG_MSB 31
`define RFB_STEP_BYTE 32'h0000_0001
`define RFB_STEP_WORD 32'h0000_0002
`define RFB_STEP_LONG 32'h0000_0004
`define RFB_REG_RST 32'h0000_0000
`define RFB_WORD_OFS 32'h0000_0002
`define RFB_HI_LSB 16
`define RFB_BYTE_HI_LSB 8
`define RFB_DIGIT_MSB 3
`define RFB_DIGIT_HI_LSB 4
`define RFB_LANE_HI 2'h2
`define RFB_LANE_LO 2'h1
`define RFB_LANE_BOTH 2'h3
`endif

// [pkg/rfb_pkg.sv]
// types for the register file and byte-order block
package rfb_pkg;
	typedef enum logic [1:0] {
		RFB_SZ_BIT = 2'b00,
		RFB_SZ_BYTE = 2'b01,
		RFB_SZ_WORD = 2'b10,
		RFB_SZ_LONG = 2'b11
	} rfb_size_t;
	typedef enum logic [1:0] {
		RFB_ST_IDLE = 2'b00,
		RFB_ST_HI = 2'b01,
		RFB_ST_LO = 2'b10
	} rfb_state_t;
	typedef struct packed {
		logic en;
		logic is_addr;
		logic [2:0] idx;
		rfb_size_t size;
		logic [4:0] bitnum;
		logic [31:0] data;
	} rfb_wr_t;
	typedef struct packed {
		logic is_addr;
		logic [2:0] idx;
		rfb_size_t size;
		logic [4:0] bitnum;
	} rfb_rd_t;
	typedef struct packed {
		logic en;
		logic [2:0] idx;
		logic dec;
		rfb_size_t size;
	} rfb_step_t;
	typedef struct packed {
		logic start;
		logic write;
		rfb_size_t size;
		logic [31:0] addr;
		logic [31:0] data;
	} rfb_mreq_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [15:0] wdata;
		logic [1:0] lanes;
	} rfb_bus_t;
endpackage

// [design/rfb_core.sv]
// register file with sized merges and big-endian memory sequencing
`timescale 1ns/1ns
`include "rfb_cfg.svh"
module rfb_core (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic supervisor,
	input wire rfb_pkg::rfb_wr_t wr,
	input wire rfb_pkg::rfb_rd_t rd,
	input wire rfb_pkg::rfb_step_t step,
	input wire rfb_pkg::rfb_mreq_t mreq,
	input wire logic bus_ack,
	input wire logic [15:0] bus_rdata,
	output logic [31:0] rd_data,
	output logic rd_size_err,
	output logic wr_size_err,
	output rfb_pkg::rfb_bus_t bus,
	output logic mem_done,
	output logic [31:0] mem_rdata,
	output logic align_fault,
	output logic [3:0] most_significant_digit,
	output logic [3:0] least_significant_digit
);
	import rfb_pkg::*;

	typedef struct packed {
		logic [`RFB_NUM_DATA-1:0][31:0] dreg;
		logic [`RFB_NUM_ADDR-2:0][31:0] areg;
		logic [31:0] user_stack_pointer;
		logic [31:0] supervisor_stack_pointer;
		logic [31:0] rd_data;
		logic rd_size_err;
		logic wr_size_err;
		rfb_state_t st;
		logic mwrite;
		logic mlong;
		logic [31:0] maddr;
		logic [31:0] mdata;
		rfb_bus_t bus;
		logic mem_done;
		logic [31:0] mem_rdata;
		logic align_fault;
		logic [3:0] hi_digit;
		logic [3:0] lo_digit;
	} rfb_state_s_t;

	rfb_state_s_t s_r;
	rfb_state_s_t s_nxt;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] sext_word(input logic [31:0] v);
		sext_word = {{16{v[`RFB_WORD_MSB]}}, v[`RFB_WORD_MSB:0]};
	endfunction

	function automatic logic [31:0] step_amount(input rfb_size_t sz, input logic is_sp);
		unique case (sz)
			RFB_SZ_LONG: step_amount = `RFB_STEP_LONG;
			RFB_SZ_WORD: step_amount = `RFB_STEP_WORD;
			default: step_amount = is_sp ? `RFB_STEP_WORD : `RFB_STEP_BYTE;
		endcase
	endfunction

	function automatic logic [31:0] areg_get(input rfb_state_s_t st, input logic [2:0] i,
			input logic sup);
		if (i == `RFB_SP_IDX)
			areg_get = sup ? st.supervisor_stack_pointer : st.user_stack_pointer;
		else
			areg_get = st.areg[i];
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] cur;
		logic [31:0] nv;
		logic [31:0] av;
		cur = '0;
		nv = '0;
		av = '0;
		s_nxt = s_r;
		s_nxt.mem_done = 1'b0;
		s_nxt.align_fault = 1'b0;
		s_nxt.wr_size_err = 1'b0;

		// read port
		s_nxt.rd_size_err = 1'b0;
		if (rd.is_addr) begin
			av = areg_get(s_r, rd.idx, supervisor);
			unique case (rd.size)
				RFB_SZ_LONG: s_nxt.rd_data = av;
				RFB_SZ_WORD: s_nxt.rd_data = {16'h0000, av[`RFB_WORD_MSB:0]};
				default: begin
					s_nxt.rd_data = `RFB_REG_RST;
					s_nxt.rd_size_err = 1'b1;
				end
			endcase
		end else begin
			cur = s_r.dreg[rd.idx];
			unique case (rd.size)
				RFB_SZ_LONG: s_nxt.rd_data = cur;
				RFB_SZ_WORD: s_nxt.rd_data = {16'h0000, cur[`RFB_WORD_MSB:0]};
				RFB_SZ_BYTE: s_nxt.rd_data = {24'h000000, cur[`RFB_BYTE_MSB:0]};
				RFB_SZ_BIT: s_nxt.rd_data = {31'h0, cur[rd.bitnum]};
			endcase
		end
		// decimal digits of the low byte read
		s_nxt.hi_digit = s_nxt.rd_data[`RFB_BYTE_MSB:`RFB_DIGIT_HI_LSB];
		s_nxt.lo_digit = s_nxt.rd_data[`RFB_DIGIT_MSB:0];

		// stack/postinc/predec stepping
		if (step.en) begin
			av = areg_get(s_r, step.idx, supervisor);
			nv = step.dec ? av - step_amount(step.size, step.idx == `RFB_SP_IDX)
				: av + step_amount(step.size, step.idx == `RFB_SP_IDX);
			if (step.idx == `RFB_SP_IDX) begin
				if (supervisor) s_nxt.supervisor_stack_pointer = nv;
				else s_nxt.user_stack_pointer = nv;
			end else begin
				s_nxt.areg[step.idx] = nv;
			end
		end

		// write port, wins over a step to the same register
		if (wr.en) begin
			if (wr.is_addr) begin
				unique case (wr.size)
					RFB_SZ_LONG: nv = wr.data;
					RFB_SZ_WORD: nv = sext_word(wr.data);
					default: nv = '0;
				endcase
				if (wr.size == RFB_SZ_BYTE || wr.size == RFB_SZ_BIT) begin
					s_nxt.wr_size_err = 1'b1;
				end else if (wr.idx == `RFB_SP_IDX) begin
					if (supervisor) s_nxt.supervisor_stack_pointer = nv;
					else s_nxt.user_stack_pointer = nv;
				end else begin
					s_nxt.areg[wr.idx] = nv;
				end
			end else begin
				cur = s_r.dreg[wr.idx];
				unique case (wr.size)
					RFB_SZ_LONG: cur = wr.data;
					RFB_SZ_WORD: cur[`RFB_WORD_MSB:0] = wr.data[`RFB_WORD_MSB:0];
					RFB_SZ_BYTE: cur[`RFB_BYTE_MSB:0] = wr.data[`RFB_BYTE_MSB:0];
					RFB_SZ_BIT: cur[wr.bitnum] = wr.data[0];
				endcase
				s_nxt.dreg[wr.idx] = cur;
			end
		end

		// memory sequencer
		unique case (s_r.st)
			RFB_ST_IDLE: begin
				s_nxt.bus.valid = 1'b0;
				if (mreq.start) begin
					if (mreq.size != RFB_SZ_BYTE && mreq.addr[0]) begin
						s_nxt.align_fault = 1'b1;
						s_nxt.mem_done = 1'b1;
					end else begin
						s_nxt.mwrite = mreq.write;
						s_nxt.mlong = mreq.size == RFB_SZ_LONG;
						s_nxt.maddr = mreq.addr;
						s_nxt.mdata = mreq.data;
						s_nxt.mem_rdata = `RFB_REG_RST;
						s_nxt.bus.valid = 1'b1;
						s_nxt.bus.write = mreq.write;
						s_nxt.bus.addr = mreq.addr;
						if (mreq.size == RFB_SZ_LONG)
							s_nxt.bus.wdata = mreq.data[`RFB_LONG_MSB:`RFB_HI_LSB];
						else if (mreq.size == RFB_SZ_BYTE)
							s_nxt.bus.wdata = {mreq.data[`RFB_BYTE_MSB:0], mreq.data[`RFB_BYTE_MSB:0]};
						else
							s_nxt.bus.wdata = mreq.data[`RFB_WORD_MSB:0];
						if (mreq.size == RFB_SZ_BYTE)
							s_nxt.bus.lanes = mreq.addr[0] ? `RFB_LANE_LO : `RFB_LANE_HI;
						else
							s_nxt.bus.lanes = `RFB_LANE_BOTH;
						s_nxt.st = RFB_ST_HI;
					end
				end
			end
			RFB_ST_HI: begin
				if (bus_ack) begin
					if (s_r.mlong) begin
						s_nxt.mem_rdata = {bus_rdata, 16'h0000};
						s_nxt.bus.addr = s_r.maddr + `RFB_WORD_OFS;
						s_nxt.bus.wdata = s_r.mdata[`RFB_WORD_MSB:0];
						s_nxt.st = RFB_ST_LO;
					end else begin
						s_nxt.bus.valid = 1'b0;
						s_nxt.mem_done = 1'b1;
						if (s_r.bus.lanes == `RFB_LANE_HI)
							s_nxt.mem_rdata = {24'h000000,
								bus_rdata[`RFB_WORD_MSB:`RFB_BYTE_HI_LSB]};
						else if (s_r.bus.lanes == `RFB_LANE_LO)
							s_nxt.mem_rdata = {24'h000000, bus_rdata[`RFB_BYTE_MSB:0]};
						else
							s_nxt.mem_rdata = {16'h0000, bus_rdata};
						s_nxt.st = RFB_ST_IDLE;
					end
				end
			end
			RFB_ST_LO: begin
				if (bus_ack) begin
					s_nxt.mem_rdata = {s_r.mem_rdata[`RFB_LONG_MSB:`RFB_HI_LSB], bus_rdata};
					s_nxt.bus.valid = 1'b0;
					s_nxt.mem_done = 1'b1;
					s_nxt.st = RFB_ST_IDLE;
				end
			end
			default: s_nxt.st = RFB_ST_IDLE;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign rd_data = s_r.rd_data;
	assign rd_size_err = s_r.rd_size_err;
	assign wr_size_err = s_r.wr_size_err;
	assign bus = s_r.bus;
	assign mem_done = s_r.mem_done;
	assign mem_rdata = s_r.mem_rdata;
	assign align_fault = s_r.align_fault;
	assign most_significant_digit = s_r.hi_digit;
	assign least_significant_digit = s_r.lo_digit;
endmodule // rfb_core

// [dv/rfb_core_assertions.sv]
// concurrent checks on the register file block ports
`timescale 1ns/1ns
module rfb_core_assertions (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire rfb_pkg::rfb_wr_t wr,
	input wire rfb_pkg::rfb_rd_t rd,
	input wire rfb_pkg::rfb_mreq_t mreq,
	input wire rfb_pkg::rfb_bus_t bus,
	input wire logic bus_ack,
	input wire logic [31:0] rd_data,
	input wire logic rd_size_err,
	input wire logic wr_size_err,
	input wire logic mem_done,
	input wire logic align_fault,
	input wire logic [3:0] most_significant_digit,
	input wire logic [3:0] least_significant_digit
);
	import rfb_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	bcd_digits_a: assert property (
		{most_significant_digit, least_significant_digit} == rd_data[7:0]) else $error("digits");
	rd_refuse_a: assert property (
		rd.is_addr && !rd.size[1] |=> rd_size_err && rd_data == 32'h0) else $error("rd refuse");
	wr_refuse_a: assert property (
		wr.en && wr.is_addr && !wr.size[1] |=> wr_size_err) else $error("wr refuse");
	odd_fault_a: assert property (
		mreq.start && !bus.valid && mreq.size != RFB_SZ_BYTE && mreq.addr[0]
		|=> align_fault && mem_done && !bus.valid) else $error("odd fault");
	first_addr_a: assert property (
		mreq.start && !bus.valid && mreq.size == RFB_SZ_LONG && !mreq.addr[0]
		|=> bus.valid && bus.addr == $past(mreq.addr)) else $error("first addr");
	bus_hold_a: assert property (
		bus.valid && !bus_ack |=> bus.valid && $stable(bus.addr) && $stable(bus.wdata))
		else $error("bus hold");
	even_word_a: assert property (
		bus.valid && bus.lanes == 2'h3 |-> !bus.addr[0]) else $error("odd word");
	done_bound_a: assert property (
		mreq.start && !bus.valid |-> ##[1:16] mem_done) else $error("no done");
	byte_zero_a: assert property (
		!rd.is_addr && rd.size == RFB_SZ_BYTE |=> rd_data[31:8] == 24'h0) else $error("byte read");
endmodule // rfb_core_assertions
bind rfb_core rfb_core_assertions rfb_core_assertions_i (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.wr(wr),
	.rd(rd),
	.mreq(mreq),
	.bus(bus),
	.bus_ack(bus_ack),
	.rd_data(rd_data),
	.rd_size_err(rd_size_err),
	.wr_size_err(wr_size_err),
	.mem_done(mem_done),
	.align_fault(align_fault),
	.most_significant_digit(most_significant_digit),
	.least_significant_digit(least_significant_digit)
);

// [dv/rfb_mem_model.sv]
// word-wide memory answering the block bus
`timescale 1ns/1ns
module rfb_mem_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire rfb_pkg::rfb_bus_t bus,
	output logic bus_ack,
	output logic [15:0] bus_rdata
);
	import rfb_pkg::*;
	logic [15:0] mem [0:15] = '{default: 16'h0};
	logic waited_r = 1'h0;
	logic ack_r = 1'h0;
	logic [15:0] rdata_r = 16'h0;
	assign bus_ack = ack_r;
	assign bus_rdata = rdata_r;
	// idle data lines invert every cycle, showing the last word's inverse and the last word in turn
	always @(posedge ref_clk) begin
		ack_r <= 1'h0;
		rdata_r <= ~rdata_r;
		if (bus.valid && !ack_r) begin
			waited_r <= slow && !waited_r;
			if (!slow || waited_r) begin
				ack_r <= 1'h1;
				rdata_r <= mem[bus.addr[4:1]];
				if (bus.write && bus.lanes[1]) mem[bus.addr[4:1]][15:8] <= bus.wdata[15:8];
				if (bus.write && bus.lanes[0]) mem[bus.addr[4:1]][7:0] <= bus.wdata[7:0];
			end
		end
	end
endmodule // rfb_mem_model

// [dv/tb.sv]
// self-checking bench for the register file block
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
	import rfb_pkg::*;
	logic ref_clk = 1'h0, nrst = 1'h0, supervisor = 1'h0, slow = 1'h0;
	rfb_wr_t wr = '0;
	rfb_rd_t rd = '0;
	rfb_step_t step = '0;
	rfb_mreq_t mreq = '0;
	rfb_bus_t bus;
	logic bus_ack, rd_size_err, wr_size_err, mem_done, align_fault;
	logic [15:0] bus_rdata;
	logic [31:0] rd_data, mem_rdata;
	logic [3:0] most_significant_digit, least_significant_digit;
	int err_count = 0, total_checks = 0, cycles = 0;
	always #2 ref_clk = ~ref_clk;
	rfb_core rfb_core_i (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.supervisor(supervisor),
		.wr(wr),
		.rd(rd),
		.step(step),
		.mreq(mreq),
		.bus_ack(bus_ack),
		.bus_rdata(bus_rdata),
		.rd_data(rd_data),
		.rd_size_err(rd_size_err),
		.wr_size_err(wr_size_err),
		.bus(bus),
		.mem_done(mem_done),
		.mem_rdata(mem_rdata),
		.align_fault(align_fault),
		.most_significant_digit(most_significant_digit),
		.least_significant_digit(least_significant_digit)
	);
	rfb_mem_model rfb_mem_model_i (
		.ref_clk(ref_clk),
		.slow(slow),
		.bus(bus),
		.bus_ack(bus_ack),
		.bus_rdata(bus_rdata)
	);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic wreg(logic a, logic [2:0] i, rfb_size_t s, logic [4:0] b, logic [31:0] d);
		@(posedge ref_clk) wr <= '{1'h1, a, i, s, b, d};
		@(posedge ref_clk) wr.en <= 1'h0;
		#1;
	endtask
	task automatic rchk(logic a, logic [2:0] i, rfb_size_t s, logic [4:0] b, logic [31:0] e);
		@(posedge ref_clk) rd <= '{a, i, s, b};
		@(posedge ref_clk) #1;
		`CHK("rd_data", e, rd_data)
	endtask
	task automatic mop(logic w, rfb_size_t s, logic [31:0] a, logic [31:0] d);
		@(posedge ref_clk) mreq <= '{1'h1, w, s, a, d};
		@(posedge ref_clk) mreq.start <= 1'h0;
		#1;
		for (int k = 0; k < 20 && mem_done !== 1'h1; k++) @(posedge ref_clk) #1;
		`CHK("mem_done", 1'h1, mem_done)
	endtask
	task automatic t_data();
		wreg(1'h0, 3'h3, RFB_SZ_LONG, 5'h0, 32'h1234_5678);
		wreg(1'h0, 3'h3, RFB_SZ_BYTE, 5'h0, 32'hffff_ff98);
		rchk(1'h0, 3'h3, RFB_SZ_LONG, 5'h0, 32'h1234_5698);
		`CHK("digits", 8'h98, {most_significant_digit, least_significant_digit})
		wreg(1'h0, 3'h3, RFB_SZ_WORD, 5'h0, 32'hffff_abcd);
		rchk(1'h0, 3'h3, RFB_SZ_LONG, 5'h0, 32'h1234_abcd);
		rchk(1'h0, 3'h3, RFB_SZ_BYTE, 5'h0, 32'h0000_00cd);
		rchk(1'h0, 3'h3, RFB_SZ_WORD, 5'h0, 32'h0000_abcd);
		wreg(1'h0, 3'h0, RFB_SZ_LONG, 5'h0, 32'h0);
		wreg(1'h0, 3'h0, RFB_SZ_BIT, 5'h1f, 32'h1);
		rchk(1'h0, 3'h0, RFB_SZ_LONG, 5'h0, 32'h8000_0000);
		rchk(1'h0, 3'h0, RFB_SZ_BIT, 5'h1f, 32'h1);
	endtask
	task automatic t_addr();
		wreg(1'h1, 3'h2, RFB_SZ_LONG, 5'h0, 32'h1234_5678);
		wreg(1'h1, 3'h2, RFB_SZ_WORD, 5'h0, 32'h0000_8001);
		rchk(1'h1, 3'h2, RFB_SZ_LONG, 5'h0, 32'hffff_8001);
		rchk(1'h1, 3'h2, RFB_SZ_WORD, 5'h0, 32'h0000_8001);
		wreg(1'h1, 3'h2, RFB_SZ_BYTE, 5'h0, 32'h55);
		`CHK("wr_size_err", 1'h1, wr_size_err)
		rchk(1'h1, 3'h2, RFB_SZ_BYTE, 5'h0, 32'h0);
		`CHK("rd_size_err", 1'h1, rd_size_err)
		wreg(1'h1, 3'h2, RFB_SZ_WORD, 5'h0, 32'hffff_7fff);
		rchk(1'h1, 3'h2, RFB_SZ_LONG, 5'h0, 32'h0000_7fff);
	endtask
	task automatic t_sp();
		@(posedge ref_clk) supervisor <= 1'h1;
		wreg(1'h1, 3'h7, RFB_SZ_LONG, 5'h0, 32'h1000);
		@(posedge ref_clk) supervisor <= 1'h0;
		wreg(1'h1, 3'h7, RFB_SZ_LONG, 5'h0, 32'h2000);
		@(posedge ref_clk) step <= '{1'h1, 3'h7, 1'h0, RFB_SZ_BYTE};
		@(posedge ref_clk) step <= '{1'h1, 3'h2, 1'h1, RFB_SZ_WORD};
		@(posedge ref_clk) step.en <= 1'h0;
		rchk(1'h1, 3'h7, RFB_SZ_LONG, 5'h0, 32'h2002);
		rchk(1'h1, 3'h2, RFB_SZ_LONG, 5'h0, 32'h0000_7ffd);
		@(posedge ref_clk) step <= '{1'h1, 3'h2, 1'h0, RFB_SZ_BYTE};
		@(posedge ref_clk) step.en <= 1'h0;
		rchk(1'h1, 3'h2, RFB_SZ_LONG, 5'h0, 32'h0000_7ffe);
		@(posedge ref_clk) supervisor <= 1'h1;
		rchk(1'h1, 3'h7, RFB_SZ_LONG, 5'h0, 32'h1000);
	endtask
	task automatic t_mem();
		mop(1'h1, RFB_SZ_LONG, 32'h8, 32'hcafe_f00d);
		`CHK("hi word", 16'hcafe, rfb_mem_model_i.mem[4])
		`CHK("lo word", 16'hf00d, rfb_mem_model_i.mem[5])
		@(posedge ref_clk) slow <= 1'h1;
		mop(1'h0, RFB_SZ_LONG, 32'h8, 32'h0);
		`CHK("mem_rdata", 32'hcafe_f00d, mem_rdata)
		mop(1'h1, RFB_SZ_BYTE, 32'h9, 32'h77);
		`CHK("odd byte", 16'hca77, rfb_mem_model_i.mem[4])
		mop(1'h0, RFB_SZ_BYTE, 32'h8, 32'h0);
		`CHK("even byte", 8'hca, mem_rdata[7:0])
		mop(1'h0, RFB_SZ_WORD, 32'h5, 32'h0);
		`CHK("align_fault", 1'h1, align_fault)
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'h1;
		t_data();
		t_addr();
		t_sp();
		t_mem();
		end_of_test();
	end
endmodule // tb
